/* aps_map.svh */
// Register map, field layout, reset values and serial frame layout of the segment bank
// What this block does
// R01: Segments shape the pulse only in arbitrary mode
// R02: Eight segments together span one master period
// R03: Amplitude is bits 6..0, bit 7 reserved
// R04: Amplitude is signed magnitude, bit 6 sign
// R05: Address 01010 feeds segment three
// R06: Address 01011 feeds segment four
// R07: Address 01100 feeds segment five
// R08: Address 01101 feeds segment six
// R09: Addresses 01000, 01001 feed segments one, two
// R10: Addresses 01110, 01111 feed segments seven, eight
// R11: Segments play one to eight, each one eighth
// R12: Registers read back last write, reset zero
`ifndef APS_MAP_SVH
`define APS_MAP_SVH

`define APS_ADDR_W 5
`define APS_DATA_W 8
`define APS_NUM_SEG 8
`define APS_SLOT_W 3
`define APS_LAST_SLOT 3'h7
`define APS_SIGN_BIT 6
`define APS_MAG_MSB 5
`define APS_AMP_MSB 6

`define APS_REG_SEG1 5'h08
`define APS_REG_SEG2 5'h09
`define APS_REG_SEG3 5'h0A
`define APS_REG_SEG4 5'h0B
`define APS_REG_SEG5 5'h0C
`define APS_REG_SEG6 5'h0D
`define APS_REG_SEG7 5'h0E
`define APS_REG_SEG8 5'h0F
`define APS_SEG_RESET 8'h00
`define APS_UNMAPPED_READ 8'h00

`define APS_PIN_IDLE 3'h4
`define APS_BIT_CNT_W 4
`define APS_BIT_RW 4'h0
`define APS_BIT_ADDR_LAST 4'h5
`define APS_BIT_HDR_LAST 4'h7
`define APS_BIT_FRAME_LAST 4'hF

`endif

/* aps_pkg.sv */
// Types shared by the segment register bank and the segment player
package aps_pkg;
`include "aps_map.svh"

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
	} aps_host_in_t;

	typedef enum logic [4:0] {
		APS_ST_IDLE = 5'h01,
		APS_ST_HDR = 5'h02,
		APS_ST_WR = 5'h04,
		APS_ST_RD = 5'h08,
		APS_ST_END = 5'h10
	} aps_ser_st_t;

	typedef struct packed {
		logic sign;
		logic [`APS_MAG_MSB:0] mag;
	} aps_amp_t;

	typedef struct packed {
		logic active;
		logic [`APS_SLOT_W-1:0] slot;
		aps_amp_t amp;
	} aps_seg_out_t;

	typedef struct packed {
		aps_ser_st_t st;
		aps_host_in_t meta;
		aps_host_in_t sync;
		logic sclk_prev;
		logic [`APS_BIT_CNT_W-1:0] bit_cnt;
		logic rw;
		logic [`APS_ADDR_W-1:0] addr;
		logic [`APS_DATA_W-1:0] shreg;
		logic sdo;
		logic sdo_oe;
		logic [`APS_NUM_SEG-1:0][`APS_DATA_W-1:0] regs;
	} aps_regs_state_t;

	typedef struct packed {
		logic active;
		logic [`APS_SLOT_W-1:0] slot;
		logic neg;
		aps_seg_out_t out;
	} aps_play_state_t;
endpackage

/* aps_seg_player.sv */
// Plays the eight segment amplitudes in order, one per segment tick
`timescale 1ns/1ns
`include "aps_map.svh"
module aps_seg_player (
	input wire logic clk_sys,
	input wire logic rst,
	input wire aps_pkg::aps_amp_t [`APS_NUM_SEG-1:0] amps,
	input wire logic arb_mode_sel,
	input wire logic pulse_start,
	input wire logic pulse_neg,
	input wire logic seg_tick,
	output aps_pkg::aps_seg_out_t seg_out
);
	import aps_pkg::*;

	aps_play_state_t q;
	aps_play_state_t d;

	// Sign flip lets the line coder send alternate marks without a second table
	function automatic aps_seg_out_t seg_word(input aps_amp_t a, input logic [2:0] s,
		input logic n);
		aps_seg_out_t w;
		w.active = 1'b1;
		w.slot = s;
		w.amp.sign = a.sign ^ n; // [R04]
		w.amp.mag = a.mag;
		return w;
	endfunction

	always_comb begin
		d = q;
		if (!arb_mode_sel) begin
			d = '0; // [R01]
		end else if (pulse_start) begin
			d.active = 1'b1;
			d.slot = '0; // [R11]
			d.neg = pulse_neg;
			d.out = seg_word(amps[0], 3'h0, pulse_neg);
		end else if (q.active && seg_tick) begin
			if (q.slot == `APS_LAST_SLOT) begin
				d.active = 1'b0; // [R02]
				d.out = '0;
			end else begin
				d.slot = 3'(q.slot + 3'h1); // [R11]
				d.out = seg_word(amps[d.slot], d.slot, q.neg);
			end
		end
		if (rst) begin
			d = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		q <= d;
	end

	assign seg_out = q.out;
endmodule

/* aps_regs.sv */
// Serial host register bank for the arbitrary transmit pulse segment amplitudes
`timescale 1ns/1ns
`include "aps_map.svh"
module aps_regs (
	input wire logic clk_sys,
	input wire logic rst,
	input wire aps_pkg::aps_host_in_t host_in,
	output logic host_sdo,
	output logic host_sdo_oe,
	input wire logic arb_mode_sel,
	input wire logic pulse_start,
	input wire logic pulse_neg,
	input wire logic seg_tick,
	output aps_pkg::aps_seg_out_t seg_out
);
	import aps_pkg::*;

	aps_regs_state_t q;
	aps_regs_state_t d;
	aps_amp_t [`APS_NUM_SEG-1:0] amps;
	logic sclk_rise;
	logic sclk_fall;
	logic hit;
	logic [`APS_SLOT_W-1:0] slot;

	// Address to segment slot; shared by the read and write paths
	function automatic logic [3:0] seg_slot(input logic [`APS_ADDR_W-1:0] a);
		logic [3:0] r;
		r = 4'h0;
		case (a)
			`APS_REG_SEG1: r = 4'h8; // [R09]
			`APS_REG_SEG2: r = 4'h9; // [R09]
			`APS_REG_SEG3: r = 4'hA; // [R05]
			`APS_REG_SEG4: r = 4'hB; // [R06]
			`APS_REG_SEG5: r = 4'hC; // [R07]
			`APS_REG_SEG6: r = 4'hD; // [R08]
			`APS_REG_SEG7: r = 4'hE; // [R10]
			`APS_REG_SEG8: r = 4'hF; // [R10]
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	// Reserved bit 7 is stored too, so a read returns exactly what was written
	generate
		for (genvar g = 0; g < `APS_NUM_SEG; g++) begin : g_amp
			assign amps[g] = q.regs[g][`APS_AMP_MSB:0]; // [R03]
		end
	endgenerate

	// Only the synchronised copies are looked at, never the first stage
	assign sclk_rise = q.sync.sclk & ~q.sclk_prev;
	assign sclk_fall = ~q.sync.sclk & q.sclk_prev;

	always_comb begin
		logic [3:0] sel;
		sel = seg_slot(q.addr);
		hit = sel[3];
		slot = sel[2:0];
	end

	always_comb begin
		logic [3:0] wsel;
		logic [`APS_DATA_W-1:0] wdata;
		d = q;
		wsel = 4'h0;
		wdata = {q.shreg[6:0], q.sync.sdi};
		d.meta = host_in;
		d.sync = q.meta;
		d.sclk_prev = q.sync.sclk;
		if (q.sync.cs_n) begin
			// Deselect aborts any frame; a partial write never lands
			d.st = APS_ST_IDLE;
			d.bit_cnt = '0;
			d.sdo = 1'b0;
			d.sdo_oe = 1'b0;
		end else begin
			case (q.st)
				APS_ST_IDLE: begin
					d.bit_cnt = '0;
					d.st = APS_ST_HDR;
				end
				APS_ST_HDR: begin
					if (sclk_rise) begin
						d.bit_cnt = 4'(q.bit_cnt + 4'h1);
						if (q.bit_cnt == `APS_BIT_RW) begin
							d.rw = q.sync.sdi;
						end else if (q.bit_cnt <= `APS_BIT_ADDR_LAST) begin
							d.addr = {q.addr[3:0], q.sync.sdi};
						end
						if (q.bit_cnt == `APS_BIT_HDR_LAST) begin
							if (q.rw) begin
								wsel = seg_slot(q.addr);
								d.shreg = wsel[3] ? q.regs[wsel[2:0]] : `APS_UNMAPPED_READ; // [R12]
								d.sdo = d.shreg[7];
								d.sdo_oe = 1'b1;
								d.st = APS_ST_RD;
							end else begin
								d.st = APS_ST_WR;
							end
						end
					end
				end
				APS_ST_WR: begin
					if (sclk_rise) begin
						d.shreg = wdata;
						d.bit_cnt = 4'(q.bit_cnt + 4'h1);
						if (q.bit_cnt == `APS_BIT_FRAME_LAST) begin
							if (hit) begin
								d.regs[slot] = wdata; // [R12]
							end
							d.st = APS_ST_END;
						end
					end
				end
				APS_ST_RD: begin
					if (sclk_fall) begin
						d.shreg = {q.shreg[6:0], 1'b0};
						d.sdo = q.shreg[6];
					end
					if (sclk_rise) begin
						d.bit_cnt = 4'(q.bit_cnt + 4'h1);
						if (q.bit_cnt == `APS_BIT_FRAME_LAST) begin
							d.sdo_oe = 1'b0;
							d.st = APS_ST_END;
						end
					end
				end
				APS_ST_END: begin
					d.sdo_oe = 1'b0;
				end
				default: begin
					d.st = APS_ST_IDLE;
				end
			endcase
		end
		if (rst) begin
			d = '0;
			d.st = APS_ST_IDLE;
			d.meta = `APS_PIN_IDLE;
			d.sync = `APS_PIN_IDLE;
			d.regs = {`APS_NUM_SEG{`APS_SEG_RESET}}; // [R12]
		end
	end

	always_ff @(posedge clk_sys) begin
		q <= d;
	end

	assign host_sdo = q.sdo;
	assign host_sdo_oe = q.sdo_oe;

	aps_seg_player u_player (
		.clk_sys(clk_sys),
		.rst(rst),
		.amps(amps),
		.arb_mode_sel(arb_mode_sel),
		.pulse_start(pulse_start),
		.pulse_neg(pulse_neg),
		.seg_tick(seg_tick),
		.seg_out(seg_out)
	);
endmodule

/* aps_chk.sv */
// Port assertions for the segment register bank
`timescale 1ns/1ns
module aps_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire aps_pkg::aps_host_in_t host_in,
	input wire logic host_sdo,
	input wire logic host_sdo_oe,
	input wire logic arb_mode_sel,
	input wire logic pulse_start,
	input wire logic pulse_neg,
	input wire logic seg_tick,
	input wire aps_pkg::aps_seg_out_t seg_out
);
	import aps_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_play;
		arb_mode_sel && !pulse_start && seg_out.active;
	endsequence
	property p_rel;
		$fell(rst) |-> seg_out == 11'h0 && !host_sdo_oe;
	endproperty
	property p_off;
		!arb_mode_sel |=> seg_out == 11'h0;
	endproperty
	property p_start;
		arb_mode_sel && pulse_start |=> seg_out.active && seg_out.slot == 3'h0;
	endproperty
	property p_step;
		s_play ##0 seg_tick && seg_out.slot != 3'h7 |=> seg_out.slot == $past(seg_out.slot) + 3'h1;
	endproperty
	property p_end;
		s_play ##0 seg_tick && seg_out.slot == 3'h7 |=> seg_out == 11'h0;
	endproperty
	property p_hold;
		s_play ##0 !seg_tick |=> seg_out.active && $stable(seg_out.slot);
	endproperty
	property p_oe;
		host_in.cs_n [*5] |-> !host_sdo_oe;
	endproperty
	property p_quiet;
		!pulse_start && !seg_out.active |=> !seg_out.active;
	endproperty
	a_rel: assert property (p_rel) else $error("outputs not clear after reset");
	a_off: assert property (p_off) else $error("output while mode off");
	a_start: assert property (p_start) else $error("pulse did not start at slot 0");
	a_step: assert property (p_step) else $error("slot did not advance by one");
	a_end: assert property (p_end) else $error("pulse did not end after slot 7");
	a_hold: assert property (p_hold) else $error("slot moved without tick");
	a_oe: assert property (p_oe) else $error("sdo driven while deselected");
	a_quiet: assert property (p_quiet) else $error("pulse began without start");
endmodule
bind aps_regs aps_chk u_aps_chk (.clk_sys(clk_sys), .rst(rst), .host_in(host_in),
	.host_sdo(host_sdo), .host_sdo_oe(host_sdo_oe), .arb_mode_sel(arb_mode_sel),
	.pulse_start(pulse_start), .pulse_neg(pulse_neg), .seg_tick(seg_tick), .seg_out(seg_out));

/* aps_host.sv */
// Host processor model sending serial register frames
`timescale 1ns/1ns
module aps_host (
	input wire logic clk_sys,
	output aps_pkg::aps_host_in_t host_in,
	input wire logic host_sdo
);
	import aps_pkg::*;
	initial host_in = 3'h4;
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] wd,
		output logic [7:0] rv);
		logic [15:0] f;
		f = {rd, a, 2'h0, wd};
		host_in.cs_n = 1'b0;
		for (int i = 0; i < 16; i++) begin
			host_in.sdi = f[15 - i];
			repeat (6) @(negedge clk_sys);
			host_in.sclk = 1'b1;
			repeat (4) @(negedge clk_sys);
			// Device moves to the next bit on each fall, so take it late in the high phase
			if (i >= 7 && i < 15) rv = {rv[6:0], host_sdo};
			host_in.sclk = 1'b0;
		end
		// Released data line carries no pull, so show the inverse
		host_in.sdi = ~host_in.sdi;
		repeat (2) @(negedge clk_sys);
		host_in.cs_n = 1'b1;
		repeat (6) @(negedge clk_sys);
	endtask
endmodule

/* testbench.sv */
// Self-checking bench for the segment bank and player
`timescale 1ns/1ns
module testbench;
	import aps_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic arb_mode_sel = 1'b0;
	logic pulse_start = 1'b0;
	logic pulse_neg = 1'b0;
	logic seg_tick = 1'b0;
	aps_host_in_t host_in;
	logic host_sdo;
	logic host_sdo_oe;
	aps_seg_out_t seg_out;
	logic [7:0] val [8];
	logic [7:0] rv;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int oe_cyc = 0;
	always #25 clk_sys = ~clk_sys;
	// Counted on the falling edge, where the registered enable has settled
	always @(negedge clk_sys) begin
		if (host_sdo_oe === 1'b1) oe_cyc++;
	end
	aps_regs u_aps_regs (.clk_sys(clk_sys), .rst(rst), .host_in(host_in),
		.host_sdo(host_sdo), .host_sdo_oe(host_sdo_oe), .arb_mode_sel(arb_mode_sel),
		.pulse_start(pulse_start), .pulse_neg(pulse_neg), .seg_tick(seg_tick),
		.seg_out(seg_out));
	aps_host u_aps_host (.clk_sys(clk_sys), .host_in(host_in), .host_sdo(host_sdo));
	task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_rw;
		int n0;
		for (int i = 0; i < 8; i++) begin
			n0 = oe_cyc;
			u_aps_host.xfer(1'b1, 5'h08 + 5'(i), 8'h00, rv);
			cmp({3'h0, rv}, 11'h000);
			cmp(11'(oe_cyc - n0), 11'h050);
			val[i] = 8'hC5 ^ (8'(i) * 8'h29);
			u_aps_host.xfer(1'b0, 5'h08 + 5'(i), val[i], rv);
		end
		n0 = oe_cyc;
		u_aps_host.xfer(1'b0, 5'h07, 8'h7F, rv);
		cmp(11'(oe_cyc - n0), 11'h000);
		u_aps_host.xfer(1'b1, 5'h07, 8'h00, rv);
		cmp({3'h0, rv}, 11'h000);
		for (int i = 0; i < 8; i++) begin
			u_aps_host.xfer(1'b1, 5'h08 + 5'(i), 8'h00, rv);
			cmp({3'h0, rv}, {3'h0, val[i]});
		end
	endtask
	task automatic t_play(input logic neg);
		@(negedge clk_sys);
		arb_mode_sel = 1'b1;
		pulse_neg = neg;
		pulse_start = 1'b1;
		@(negedge clk_sys);
		pulse_start = 1'b0;
		for (int s = 0; s < 8; s++) begin
			repeat (2) @(negedge clk_sys);
			cmp(seg_out, {1'b1, 3'(s), val[s][6:0] ^ {neg, 6'h00}});
			seg_tick = 1'b1;
			@(negedge clk_sys);
			seg_tick = 1'b0;
		end
		@(negedge clk_sys);
		cmp(seg_out, 11'h000);
	endtask
	task automatic t_off;
		pulse_start = 1'b1;
		@(negedge clk_sys);
		pulse_start = 1'b0;
		arb_mode_sel = 1'b0;
		repeat (2) @(negedge clk_sys);
		cmp(seg_out, 11'h000);
		pulse_start = 1'b1;
		repeat (2) @(negedge clk_sys);
		pulse_start = 1'b0;
		cmp(seg_out, 11'h000);
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (16) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_rw();
		t_play(1'b0);
		t_play(1'b1);
		t_off();
		wrap_up();
	end
endmodule
